// File: inc/mmdec_pkg.sv
`default_nettype none
package mmdec_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam logic [23:0] FREG_LO = 24'hFFF000;
  localparam logic [23:0] RSV_TRAP_LO = 24'hF80000;
  localparam logic [23:0] PROGRAM_SRAM_LO = 24'hE00000;
  localparam logic [23:0] PROGRAM_SRAM_HI = 24'hE007FF;
  localparam logic [23:0] PROG_RSV_LO = 24'hC20000;
  localparam logic [23:0] FLASH_LO = 24'hC00000;
  localparam logic [23:0] FLASH_HI = 24'hC1FFFF;
  localparam logic [7:0] RSV_SEG = 8'hBF;
  localparam logic [23:0] EXTMEM_LO = 24'h400000;
  localparam logic [23:0] EXTIO_LO = 24'h200800;
  localparam logic [23:0] CAN_LO = 24'h200000;
  localparam logic [23:0] SEG0_DATA_LO = 24'h008000;
  localparam logic [7:0] SYS_SEG = 8'h00;
  // Segment 0 sub-map of the on-chip data areas.
  localparam logic [23:0] DATA_SRAM_LO = 24'h00C000;
  localparam logic [23:0] DATA_SRAM_HI = 24'h00CFFF;
  localparam logic [23:0] EXTENDED_REGISTER_AREA_LO = 24'h00F000;
  localparam logic [23:0] EXTENDED_REGISTER_AREA_HI = 24'h00F1FF;
  localparam logic [23:0] DUAL_PORT_RAM_LO = 24'h00F600;
  localparam logic [23:0] DUAL_PORT_RAM_BIT_LO = 24'h00FD00;
  localparam logic [23:0] DUAL_PORT_RAM_HI = 24'h00FDFF;
  localparam logic [23:0] SFR_LO = 24'h00FE00;

  // ----------------------------------------------------------------
  // Flash register window and unlock sequence
  // ----------------------------------------------------------------
  localparam logic [11:0] FREG_DEF_LIM = 12'h020;
  localparam logic [11:0] KEY1_OFS = 12'h0A8;
  localparam logic [11:0] KEY2_OFS = 12'h054;
  localparam logic [11:0] LOCK_OFS = 12'h010;
  localparam logic [15:0] KEY1_VAL = 16'hA5A5;
  localparam logic [15:0] KEY2_VAL = 16'h5A5A;
  localparam logic [15:0] TRAP_CODE = 16'h9B9B;
  localparam int FLASH_W = 64;
  localparam int CODE_W = 72;

  typedef enum logic [3:0] {
    TGT_EXT = 4'h0,
    TGT_LOCAL_EXPANSION_BUS = 4'h1,
    TGT_FLASH = 4'h2,
    TGT_PROGRAM_SRAM = 4'h3,
    TGT_DATA_SRAM = 4'h4,
    TGT_DUAL_PORT_RAM = 4'h5,
    TGT_SFR = 4'h6,
    TGT_EXTENDED_REGISTER_AREA = 4'h7,
    TGT_FREG = 4'h8,
    TGT_TRAP = 4'h9
  } mmdec_tgt_e;

  typedef enum logic [0:0] {
    MGR_PROG = 1'h0,
    MGR_DATA = 1'h1
  } mmdec_mgr_e;

  typedef enum logic [0:0] {
    PW_IDLE = 1'h0,
    PW_KEY1 = 1'h1
  } mmdec_pw_e;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic write;
    logic byte_acc;
    logic bit_acc;
    logic general_register;
    logic [23:0] addr;
    logic [15:0] wdata;
  } mmdec_req_s;

  typedef struct packed {
    logic valid;
    mmdec_tgt_e tgt;
    mmdec_mgr_e owner;
    logic sysbus;
    logic [23:0] addr;
    logic byte_acc;
    logic write;
    logic bit_acc;
    logic trap;
    logic rd_trap;
    logic no_pipe_opt;
    logic [2:0] sector;
    logic [1:0] wp_group;
    logic [9:0] prog_page;
  } mmdec_rsp_s;

endpackage
`default_nettype wire

// File: logic/mmdec_router.sv
// Functional notes
// - Address space is 16 Mbytes: 256 segments of 64K, four 16K pages each.
// - Byte and word accesses are accepted at every address.
// - Data memories and both register areas live in segment 0.
// - Instruction fetches belong to the program fetch manager, owner of flash and program SRAM.
// - Data transfers belong to the data transfer manager, owner of data SRAM and peripherals.
// - Cross-manager and external traffic is flagged for the two-way system bus.
// - Flash has four 8K sectors, one 32K and one 64K sector.
// - The 32K and 64K sectors are individually protected; programming is in 128-byte pages.
// - Small 8K sectors share write protection in pairs.
// - Flash read protection lifts only after the correct password sequence.
// - Flash read path returns 64 bits in one cycle.
// - Every flash read passes single-error correction before return.
// - Program SRAM decodes at E0'0000 to E0'07FF via the program manager.
// - The 4K data SRAM is reached through the data transfer manager.
// - Dual-port RAM holds register banks with word and byte registers.
// - Top 256 bytes of dual-port RAM, or any register-bank use, are bit-addressable.
// - Two 512-byte register areas of word-wide control registers are reserved.
// - Undefined reads in FF'F000 to FF'FFFF return a trap code.
// - External memory and IO regions are forwarded to the external bus.
// - External IO region 20'0800 to 3F'FFFF suppresses pipeline optimisations.
`timescale 1ns/1ns
`default_nettype none
module mmdec_router
(
  input wire logic core_clk,
  input wire logic rst,
  input wire mmdec_pkg::mmdec_req_s req,
  input wire logic [3:0] write_protect,
  input wire logic read_protect_en,
  input wire logic flash_rd_valid,
  input wire logic [71:0] flash_code,
  output var mmdec_pkg::mmdec_rsp_s rsp_ff,
  output logic [15:0] trap_data_ff,
  output logic unlocked_ff,
  output logic flash_dvalid_ff,
  output logic [63:0] flash_data_ff,
  output logic ecc_fix_ff,
  output logic ecc_err_ff
);

  // ----------------------------------------------------------------
  // Error correction helpers
  // ----------------------------------------------------------------
  // Bit 7 is overall parity; bits 6:0 locate a single flipped bit.
  function automatic logic [7:0] mmdec_syndrome(input logic [71:0] c);
    logic [6:0] s;
    s = 7'h00;
    for (int i = 1; i < 72; i++)
    begin
      if (c[i])
      begin
        s = s ^ i[6:0];
      end
    end
    return {^c, s};
  endfunction

  function automatic logic [63:0] mmdec_extract(input logic [71:0] c);
    logic [63:0] d;
    int j;
    d = 64'h0;
    j = 0;
    for (int i = 3; i < 72; i++)
    begin
      if ((i & (i - 1)) != 0)
      begin
        d[j[5:0]] = c[i];
        j = j + 1;
      end
    end
    return d;
  endfunction

  function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  mmdec_pkg::mmdec_rsp_s nxt_rsp;
  mmdec_pkg::mmdec_pw_e pw_state_ff;
  logic [23:0] a;
  logic bit_ok;

  assign a = req.addr;

  always_comb
  begin
    nxt_rsp = '0;
    nxt_rsp.valid = req.valid;
    nxt_rsp.addr = a;
    nxt_rsp.byte_acc = req.byte_acc;
    nxt_rsp.write = req.write;
    nxt_rsp.bit_acc = req.bit_acc;
    nxt_rsp.tgt = mmdec_pkg::TGT_EXT;
    nxt_rsp.prog_page = a[16:7];
    if (a >= mmdec_pkg::FREG_LO)
    begin
      nxt_rsp.tgt = mmdec_pkg::TGT_FREG;
      nxt_rsp.rd_trap = !req.write && (a[11:0] >= mmdec_pkg::FREG_DEF_LIM);
    end
    else if (a >= mmdec_pkg::RSV_TRAP_LO)
    begin
      nxt_rsp.trap = 1'b1;
    end
    else if (in_rng(a, mmdec_pkg::PROGRAM_SRAM_LO, mmdec_pkg::PROGRAM_SRAM_HI))
    begin
      nxt_rsp.tgt = mmdec_pkg::TGT_PROGRAM_SRAM;
    end
    else if (in_rng(a, mmdec_pkg::FLASH_LO, mmdec_pkg::FLASH_HI))
    begin
      nxt_rsp.tgt = mmdec_pkg::TGT_FLASH;
    end
    else if (a >= mmdec_pkg::PROG_RSV_LO || a[23:16] == mmdec_pkg::RSV_SEG)
    begin
      nxt_rsp.trap = 1'b1;
    end
    else if (a >= mmdec_pkg::EXTMEM_LO)
    begin
      nxt_rsp.tgt = mmdec_pkg::TGT_EXT;
    end
    else if (a >= mmdec_pkg::EXTIO_LO)
    begin
      nxt_rsp.no_pipe_opt = 1'b1;
    end
    else if (a >= mmdec_pkg::CAN_LO)
    begin
      nxt_rsp.tgt = mmdec_pkg::TGT_LOCAL_EXPANSION_BUS;
    end
    else if (a[23:16] != mmdec_pkg::SYS_SEG || a < mmdec_pkg::SEG0_DATA_LO)
    begin
      nxt_rsp.tgt = mmdec_pkg::TGT_EXT;
    end
    else if (in_rng(a, mmdec_pkg::DATA_SRAM_LO, mmdec_pkg::DATA_SRAM_HI))
    begin
      nxt_rsp.tgt = mmdec_pkg::TGT_DATA_SRAM;
    end
    else if (in_rng(a, mmdec_pkg::DUAL_PORT_RAM_LO, mmdec_pkg::DUAL_PORT_RAM_HI))
    begin
      nxt_rsp.tgt = mmdec_pkg::TGT_DUAL_PORT_RAM;
    end
    else if (in_rng(a, mmdec_pkg::EXTENDED_REGISTER_AREA_LO, mmdec_pkg::EXTENDED_REGISTER_AREA_HI))
    begin
      nxt_rsp.tgt = mmdec_pkg::TGT_EXTENDED_REGISTER_AREA;
    end
    else if (a >= mmdec_pkg::SFR_LO)
    begin
      nxt_rsp.tgt = mmdec_pkg::TGT_SFR;
    end
    else
    begin
      nxt_rsp.trap = 1'b1;
    end

    if (a[16])
    begin
      nxt_rsp.sector = 3'h5;
    end
    else if (a[15])
    begin
      nxt_rsp.sector = 3'h4;
    end
    else
    begin
      nxt_rsp.sector = {1'b0, a[14:13]};
    end
    nxt_rsp.wp_group = a[16] ? 2'h3 : (a[15] ? 2'h2 : {1'b0, a[14]});
    if (nxt_rsp.tgt == mmdec_pkg::TGT_FLASH)
    begin
      if (req.write && write_protect[nxt_rsp.wp_group])
      begin
        nxt_rsp.trap = 1'b1;
      end
      if (!req.write && !req.fetch && read_protect_en && !unlocked_ff)
      begin
        nxt_rsp.trap = 1'b1;
      end
    end

    bit_ok = (nxt_rsp.tgt == mmdec_pkg::TGT_DUAL_PORT_RAM && (a >= mmdec_pkg::DUAL_PORT_RAM_BIT_LO || req.general_register))
      || nxt_rsp.tgt == mmdec_pkg::TGT_SFR || nxt_rsp.tgt == mmdec_pkg::TGT_EXTENDED_REGISTER_AREA;
    if (req.bit_acc && !bit_ok)
    begin
      nxt_rsp.trap = 1'b1;
    end
    if (nxt_rsp.trap)
    begin
      nxt_rsp.tgt = mmdec_pkg::TGT_TRAP;
      nxt_rsp.no_pipe_opt = 1'b0;
    end

    if (nxt_rsp.tgt == mmdec_pkg::TGT_FLASH || nxt_rsp.tgt == mmdec_pkg::TGT_PROGRAM_SRAM)
    begin
      nxt_rsp.owner = mmdec_pkg::MGR_PROG;
    end
    else
    begin
      nxt_rsp.owner = mmdec_pkg::MGR_DATA;
    end
    nxt_rsp.sysbus = !nxt_rsp.trap && (((req.fetch ? mmdec_pkg::MGR_PROG : mmdec_pkg::MGR_DATA) != nxt_rsp.owner)
      || nxt_rsp.tgt == mmdec_pkg::TGT_EXT || nxt_rsp.tgt == mmdec_pkg::TGT_LOCAL_EXPANSION_BUS);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rsp_ff <= '0;
    end
    else
    begin
      rsp_ff <= nxt_rsp;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      trap_data_ff <= 16'h0000;
    end
    else
    begin
      trap_data_ff <= (req.valid && nxt_rsp.rd_trap) ? mmdec_pkg::TRAP_CODE : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Password unlock
  // ----------------------------------------------------------------
  // Unlock is temporary: it ends at reset, or at a write to the lock offset while no first key is pending.
  logic freg_wr;

  assign freg_wr = req.valid && req.write && a >= mmdec_pkg::FREG_LO;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pw_state_ff <= mmdec_pkg::PW_IDLE;
      unlocked_ff <= 1'b0;
    end
    else if (freg_wr)
    begin
      case (pw_state_ff)
        mmdec_pkg::PW_IDLE:
        begin
          if (a[11:0] == mmdec_pkg::KEY1_OFS && req.wdata == mmdec_pkg::KEY1_VAL)
          begin
            pw_state_ff <= mmdec_pkg::PW_KEY1;
          end
          if (a[11:0] == mmdec_pkg::LOCK_OFS)
          begin
            unlocked_ff <= 1'b0;
          end
        end
        mmdec_pkg::PW_KEY1:
        begin
          pw_state_ff <= mmdec_pkg::PW_IDLE;
          if (a[11:0] == mmdec_pkg::KEY2_OFS && req.wdata == mmdec_pkg::KEY2_VAL)
          begin
            unlocked_ff <= 1'b1;
          end
        end
        default:
        begin
          pw_state_ff <= mmdec_pkg::PW_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flash read path
  // ----------------------------------------------------------------
  logic [7:0] syn;
  logic [71:0] fixed;

  always_comb
  begin
    syn = mmdec_syndrome(flash_code);
    fixed = flash_code;
    if (syn[7])
    begin
      fixed[syn[6:0]] = ~flash_code[syn[6:0]];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      flash_dvalid_ff <= 1'b0;
      flash_data_ff <= 64'h0;
      ecc_fix_ff <= 1'b0;
      ecc_err_ff <= 1'b0;
    end
    else
    begin
      flash_dvalid_ff <= flash_rd_valid;
      flash_data_ff <= mmdec_extract(fixed);
      ecc_fix_ff <= flash_rd_valid && syn[7];
      ecc_err_ff <= flash_rd_valid && !syn[7] && syn[6:0] != 7'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_rsp_one_cycle: assert property (req.valid |=> rsp_ff.valid && rsp_ff.addr == $past(req.addr))
    else $error("Decode answer missing one cycle after request.");
  a_reserved_trap: assert property (req.valid && in_rng(req.addr, 24'hF80000, 24'hFFEFFF)
    |=> rsp_ff.trap && rsp_ff.tgt == mmdec_pkg::TGT_TRAP)
    else $error("Reserved region did not trap.");
  a_extio_order: assert property (req.valid && !req.bit_acc && in_rng(req.addr, 24'h200800, 24'h3FFFFF)
    |=> rsp_ff.no_pipe_opt && rsp_ff.tgt == mmdec_pkg::TGT_EXT)
    else $error("External IO access kept pipeline optimisations.");
  a_can_local_expansion_bus: assert property (req.valid && !req.bit_acc && in_rng(req.addr, 24'h200000, 24'h2007FF)
    |=> rsp_ff.tgt == mmdec_pkg::TGT_LOCAL_EXPANSION_BUS && rsp_ff.sysbus)
    else $error("Expansion window not routed to the expansion bus.");
  a_program_sram_owner: assert property (req.valid && !req.bit_acc && in_rng(req.addr, 24'hE00000, 24'hE007FF)
    |=> rsp_ff.tgt == mmdec_pkg::TGT_PROGRAM_SRAM && rsp_ff.owner == mmdec_pkg::MGR_PROG)
    else $error("Program SRAM not owned by the program manager.");
  a_wp_trap: assert property (req.valid && req.write && write_protect == 4'hF
    && in_rng(req.addr, 24'hC00000, 24'hC1FFFF) |=> rsp_ff.trap)
    else $error("Write to protected flash completed.");
  a_freg_code: assert property (req.valid && !req.write && req.addr >= 24'hFFF020
    |=> trap_data_ff == mmdec_pkg::TRAP_CODE)
    else $error("Undefined flash register read returned no trap code.");
  a_unlock_seq: assert property (freg_wr && pw_state_ff == mmdec_pkg::PW_KEY1 && a[11:0] == 12'h054
    && req.wdata == 16'h5A5A |=> unlocked_ff ##1 unlocked_ff || $past(freg_wr))
    else $error("Password sequence did not unlock flash.");
  a_ecc_latency: assert property (flash_rd_valid |=> flash_dvalid_ff && !(ecc_fix_ff && ecc_err_ff))
    else $error("Flash data not returned one cycle after read.");

endmodule
`default_nettype wire

// File: verification/mmdec_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module mmdec_core_model
(
  input wire mmdec_pkg::mmdec_req_s cmd,
  output var mmdec_pkg::mmdec_req_s req
);
  // ------
  // Core side of the access bus
  // ------
  always_comb
  begin
    req = cmd;
    if (cmd.write && cmd.addr >= mmdec_pkg::EXTENDED_REGISTER_AREA_LO && cmd.addr <= 24'h00FFFF)
    begin
      req.wdata = 16'h0000;
    end
    // An idle core leaves the lines undriven, so stale values must never look valid.
    if (!cmd.valid)
    begin
      req = ~cmd;
      req.valid = 1'h0;
    end
  end
endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk;
  logic rst;
  mmdec_pkg::mmdec_req_s cmd;
  mmdec_pkg::mmdec_req_s req;
  mmdec_pkg::mmdec_req_s pr;
  mmdec_pkg::mmdec_rsp_s rsp_ff;
  logic [3:0] write_protect;
  logic read_protect_en;
  logic flash_rd_valid;
  logic [71:0] flash_code;
  logic [15:0] trap_data_ff;
  logic unlocked_ff;
  logic flash_dvalid_ff;
  logic [63:0] flash_data_ff;
  logic ecc_fix_ff;
  logic ecc_err_ff;
  int n_mismatch;
  int tests_run;
  int seed;
  logic armed;
  logic unl;
  logic pend;
  logic e_trap;
  logic [40:0] seqt [0:11] = '{41'h0C001000000, 41'h0FFF0200000, 41'h1FFF0A8A5A5, 41'h000C0000000,
    41'h1FFF0545A5A, 41'h0C001000000, 41'h1FFF0100000, 41'h0C1FFFE0000, 41'h1FFF0A8A5A5,
    41'h1FFF0541234, 41'h1FFF0545A5A, 41'h0C001000000};
  logic [23:0] corner [0:31] = '{24'hFFF000, 24'hFFF020, 24'hFFEFFF, 24'hF80000, 24'hF7FFFF, 24'hE007FF,
    24'hE00800, 24'hC1FFFF, 24'hC20000, 24'hBF0000, 24'hBEFFFF, 24'h400000, 24'h3FFFFF, 24'h200800,
    24'h2007FF, 24'h200000, 24'h1FFFFF, 24'h010000, 24'h007FFF, 24'h008000, 24'h00C000, 24'h00CFFF,
    24'h00F600, 24'h00FDFF, 24'h00FD00, 24'h00F000, 24'h00F1FF, 24'h00FE00, 24'h00FFFF, 24'hC06000,
    24'hC08000, 24'hC10000};

  mmdec_core_model core (.cmd(cmd), .req(req));
  mmdec_router uut (.core_clk(core_clk), .rst(rst), .req(req), .write_protect(write_protect),
    .read_protect_en(read_protect_en), .flash_rd_valid(flash_rd_valid), .flash_code(flash_code),
    .rsp_ff(rsp_ff), .trap_data_ff(trap_data_ff), .unlocked_ff(unlocked_ff), .flash_dvalid_ff(flash_dvalid_ff),
    .flash_data_ff(flash_data_ff), .ecc_fix_ff(ecc_fix_ff), .ecc_err_ff(ecc_err_ff));

  initial
  begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  // ------
  // Expectation functions
  // ------
  // Region decode order.
  function automatic mmdec_pkg::mmdec_tgt_e region(logic [23:0] a);
    if (a >= mmdec_pkg::FREG_LO) return mmdec_pkg::TGT_FREG;
    if (a >= mmdec_pkg::RSV_TRAP_LO) return mmdec_pkg::TGT_TRAP;
    if (a >= mmdec_pkg::PROGRAM_SRAM_LO && a <= mmdec_pkg::PROGRAM_SRAM_HI) return mmdec_pkg::TGT_PROGRAM_SRAM;
    if (a >= mmdec_pkg::FLASH_LO && a <= mmdec_pkg::FLASH_HI) return mmdec_pkg::TGT_FLASH;
    if (a >= mmdec_pkg::PROG_RSV_LO || a[23:16] == mmdec_pkg::RSV_SEG) return mmdec_pkg::TGT_TRAP;
    if (a >= mmdec_pkg::EXTIO_LO) return mmdec_pkg::TGT_EXT;
    if (a >= mmdec_pkg::CAN_LO) return mmdec_pkg::TGT_LOCAL_EXPANSION_BUS;
    if (a[23:16] != mmdec_pkg::SYS_SEG || a < mmdec_pkg::SEG0_DATA_LO) return mmdec_pkg::TGT_EXT;
    if (a >= mmdec_pkg::DATA_SRAM_LO && a <= mmdec_pkg::DATA_SRAM_HI) return mmdec_pkg::TGT_DATA_SRAM;
    if (a >= mmdec_pkg::DUAL_PORT_RAM_LO && a <= mmdec_pkg::DUAL_PORT_RAM_HI) return mmdec_pkg::TGT_DUAL_PORT_RAM;
    if (a >= mmdec_pkg::EXTENDED_REGISTER_AREA_LO && a <= mmdec_pkg::EXTENDED_REGISTER_AREA_HI) return mmdec_pkg::TGT_EXTENDED_REGISTER_AREA;
    if (a >= mmdec_pkg::SFR_LO) return mmdec_pkg::TGT_SFR;
    return mmdec_pkg::TGT_TRAP;
  endfunction

  function automatic logic [2:0] sector(logic [23:0] a);
    if (a[16:15] == 2'h0) return {1'h0, a[14:13]};
    return a[16] ? 3'h5 : 3'h4;
  endfunction

  function automatic logic [1:0] grp(logic [2:0] s);
    return s[2] ? {1'h1, s[0]} : {1'h0, s[1]};
  endfunction

  function automatic logic trapx(mmdec_pkg::mmdec_req_s r);
    mmdec_pkg::mmdec_tgt_e t;
    t = region(r.addr);
    if (t == mmdec_pkg::TGT_TRAP) return 1'h1;
    if (r.bit_acc && !(t == mmdec_pkg::TGT_DUAL_PORT_RAM && (r.addr >= mmdec_pkg::DUAL_PORT_RAM_BIT_LO || r.general_register))
        && t != mmdec_pkg::TGT_SFR && t != mmdec_pkg::TGT_EXTENDED_REGISTER_AREA) return 1'h1;
    if (t == mmdec_pkg::TGT_FLASH && r.write) return write_protect[grp(sector(r.addr))];
    return t == mmdec_pkg::TGT_FLASH && !r.fetch && read_protect_en && !unl;
  endfunction

  function automatic logic [71:0] enc(logic [63:0] d);
    logic [71:0] c;
    int k;
    c = '0;
    k = 0;
    for (int i = 1; i < 72; i++)
      if ((i & (i - 1)) != 0)
      begin
        c[i] = d[k];
        k++;
      end
    for (int p = 1; p < 72; p = p * 2)
      for (int i = 1; i < 72; i++)
        if ((i & p) != 0 && i != p) c[p] = c[p] ^ c[i];
    c[0] = ^c[71:1];
    return c;
  endfunction

  function automatic mmdec_pkg::mmdec_req_s mk(logic [23:0] a, logic w, logic f, logic [15:0] d);
    mmdec_pkg::mmdec_req_s r;
    r = '0;
    r.valid = 1'h1;
    r.addr = a;
    r.write = w;
    r.fetch = f & !w;
    r.wdata = d;
    r.byte_acc = 1'($random(seed));
    return r;
  endfunction

  function automatic logic [23:0] raddr();
    logic [31:0] x;
    logic [23:0] a;
    x = $random(seed);
    a = x[23:0];
    case (x[26:24])
      3'h0: a[23:16] = 8'h00;
      3'h1: a[23:17] = 7'h60;
      3'h2: a[23:12] = 12'hFFF;
      3'h3: a[23:12] = 12'h200;
      default: a = x[23:0];
    endcase
    return a;
  endfunction

  // ------
  // Compare, check and drive tasks
  // ------
  task automatic cmp_b(string n, logic e, logic g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_v(string n, logic [63:0] e, logic [63:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check();
    mmdec_pkg::mmdec_tgt_e t;
    mmdec_pkg::mmdec_mgr_e own;
    logic ft;
    t = region(pr.addr);
    own = (t == mmdec_pkg::TGT_FLASH || t == mmdec_pkg::TGT_PROGRAM_SRAM) ? mmdec_pkg::MGR_PROG : mmdec_pkg::MGR_DATA;
    ft = t == mmdec_pkg::TGT_FREG && !pr.write && pr.addr[11:0] >= mmdec_pkg::FREG_DEF_LIM;
    cmp_b("unlocked", unl, unlocked_ff);
    cmp_b("valid", pend, rsp_ff.valid);
    if (pend)
    begin
      cmp_b("byte", pr.byte_acc, rsp_ff.byte_acc);
      cmp_v("addr", 64'(pr.addr), 64'(rsp_ff.addr));
      cmp_b("write", pr.write, rsp_ff.write);
      cmp_b("bit_acc", pr.bit_acc, rsp_ff.bit_acc);
      cmp_b("trap", e_trap, rsp_ff.trap);
      cmp_v("tgt", 64'(e_trap ? mmdec_pkg::TGT_TRAP : t), 64'(rsp_ff.tgt));
      cmp_b("rd_trap", ft, rsp_ff.rd_trap);
      cmp_v("trap_data", 64'(ft ? mmdec_pkg::TRAP_CODE : 16'h0000), 64'(trap_data_ff));
      cmp_b("sysbus", !e_trap && ((pr.fetch ? mmdec_pkg::MGR_PROG : mmdec_pkg::MGR_DATA) != own
        || t == mmdec_pkg::TGT_EXT || t == mmdec_pkg::TGT_LOCAL_EXPANSION_BUS), rsp_ff.sysbus);
      cmp_b("no_pipe", !e_trap && pr.addr >= mmdec_pkg::EXTIO_LO && pr.addr < mmdec_pkg::EXTMEM_LO,
        rsp_ff.no_pipe_opt);
      if (!e_trap) cmp_v("owner", 64'(own), 64'(rsp_ff.owner));
      if (!e_trap && t == mmdec_pkg::TGT_FLASH)
      begin
        cmp_v("sector", 64'(sector(pr.addr)), 64'(rsp_ff.sector));
        cmp_v("group", 64'(grp(sector(pr.addr))), 64'(rsp_ff.wp_group));
        cmp_v("page", 64'(pr.addr[16:7]), 64'(rsp_ff.prog_page));
      end
    end
  endtask

  task automatic step(mmdec_pkg::mmdec_req_s r, logic [3:0] wp, logic rp);
    @(negedge core_clk);
    check();
    cmd = r;
    pr = r;
    pend = r.valid;
    write_protect = wp;
    read_protect_en = rp;
    e_trap = trapx(r);
    if (r.valid && r.write && r.addr >= mmdec_pkg::FREG_LO && !r.bit_acc)
    begin
      if (armed) unl = unl | (r.addr[11:0] == mmdec_pkg::KEY2_OFS && r.wdata == mmdec_pkg::KEY2_VAL);
      else if (r.addr[11:0] == mmdec_pkg::LOCK_OFS) unl = 1'h0;
      armed = !armed && r.addr[11:0] == mmdec_pkg::KEY1_OFS && r.wdata == mmdec_pkg::KEY1_VAL;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ------
  // Main sequence
  // ------
  initial
  begin
    mmdec_pkg::mmdec_req_s r;
    logic [63:0] d;
    logic [71:0] c;
    int p1;
    seed = 8;
    n_mismatch = 0;
    tests_run = 0;
    rst = 1'h1;
    cmd = '0;
    pr = '0;
    write_protect = 4'h0;
    read_protect_en = 1'h0;
    flash_rd_valid = 1'h0;
    flash_code = '0;
    armed = 1'h0;
    unl = 1'h0;
    pend = 1'h0;
    repeat (8) @(negedge core_clk);
    rst = 1'h0;
    cmp_b("rsp_idle", 1'h0, |rsp_ff);
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 32; i++)
      begin
        r = mk(corner[i], 1'h0, 1'($random(seed)), 16'h0000);
        r.bit_acc = p[0];
        r.general_register = 1'($random(seed));
        step(r, 4'h0, 1'h0);
      end
    for (int i = 0; i < 12; i++) step(mk(seqt[i][39:16], seqt[i][40], 1'h0, seqt[i][15:0]), 4'h0, 1'h1);
    for (int n = 0; n < 800; n++)
    begin
      r = mk(raddr(), 1'($random(seed)), 1'($random(seed)), 16'($random(seed)));
      r.valid = 3'($random(seed)) != 3'h0;
      r.general_register = 1'($random(seed));
      r.bit_acc = r.addr < mmdec_pkg::FREG_LO && 2'($random(seed)) == 2'h0;
      step(r, 4'($random(seed)), 1'($random(seed)));
    end
    for (int i = 2; i < 5; i++) step(mk(seqt[i][39:16], seqt[i][40], 1'h0, seqt[i][15:0]), 4'h0, 1'h1);
    r = cmd;
    r.valid = 1'h0;
    step(r, 4'h0, 1'h1);
    for (int m = 0; m < 30; m++)
    begin
      d = {$random(seed), $random(seed)};
      c = enc(d);
      p1 = {$random(seed)} % 72;
      if (m % 3 > 0) c[p1] = ~c[p1];
      if (m % 3 == 2) c[(p1 + 1 + m) % 72] = ~c[(p1 + 1 + m) % 72];
      @(negedge core_clk);
      flash_rd_valid = 1'h1;
      flash_code = c;
      @(negedge core_clk);
      flash_rd_valid = 1'h0;
      flash_code = ~c;
      cmp_b("dvalid", 1'h1, flash_dvalid_ff);
      cmp_b("fix", m % 3 == 1, ecc_fix_ff);
      cmp_b("err", m % 3 == 2, ecc_err_ff);
      if (m % 3 < 2) cmp_v("fdata", d, flash_data_ff);
    end
    rst = 1'h1;
    repeat (2) @(negedge core_clk);
    rst = 1'h0;
    unl = 1'h0;
    armed = 1'h0;
    pend = 1'h0;
    cmp_b("unlocked_rst", 1'h0, unlocked_ff);
    for (int i = 0; i < 6; i++) step(mk(seqt[i][39:16], seqt[i][40], 1'h0, seqt[i][15:0]), 4'h0, 1'h1);
    step(r, 4'h0, 1'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
